// ---- rtl/tps_sequencer.sv ----
// Purpose: Drives TMS to walk the target TAP controllers to a requested end state.
// Assumes: The test clock is sampled by the system clock, more than six times slower.
// Notes:   TMS changes after a falling test-clock edge, targets sample on the rising one.
`timescale 1ns/100ps
module tps_sequencer
  import tps_pkg::*;
(
  input  wire logic                   clock,
  input  wire logic                   rst_n,
  input  wire logic                   tck,
  input  wire logic                   cmd_valid,
  input  wire tps_end_t               cmd_end,
  input  wire logic                   gated_mode,
  input  wire logic                   buf_stall,
  output logic                        cmd_ready,
  output logic                        cmd_done,
  output logic                        buf_parked,
  output logic                        tms,
  output logic [TAP_STATE_W-1:0]      tap_state_field
);

  // ----------------------------------------------------------------------
  // Test clock sampling
  // ----------------------------------------------------------------------
  logic tck_s1_q;
  logic tck_s2_q;
  logic tck_s3_q;
  logic tck_rise;
  logic tck_fall;

  // The first stage feeds only the second; edges come from later stages.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      tck_s1_q <= 1'b0;
      tck_s2_q <= 1'b0;
      tck_s3_q <= 1'b0;
    end else begin
      tck_s1_q <= tck;
      tck_s2_q <= tck_s1_q;
      tck_s3_q <= tck_s2_q;
    end
  end

  assign tck_rise = tck_s2_q & ~tck_s3_q;
  assign tck_fall = ~tck_s2_q & tck_s3_q;

  // ----------------------------------------------------------------------
  // State tracker
  // ----------------------------------------------------------------------
  tps_step_if stp ();
  logic     tms_q;
  tps_tap_t cur;

  assign stp.step = tck_rise;
  assign stp.tms  = tms_q;
  assign cur      = stp.state;

  tps_tap_track u_track (
    .clock (clock),
    .rst_n (rst_n),
    .stp   (stp)
  );

  // ----------------------------------------------------------------------
  // Path selection
  // ----------------------------------------------------------------------
  function automatic tps_tap_t end_to_tap(input tps_end_t e);
    case (e)
      END_RESET:    end_to_tap = TAP_RESET;
      END_IDLE:     end_to_tap = TAP_IDLE;
      END_SHIFT_DR: end_to_tap = TAP_SHIFT_DR;
      END_PAUSE_DR: end_to_tap = TAP_PAUSE_DR;
      END_SHIFT_IR: end_to_tap = TAP_SHIFT_IR;
      END_PAUSE_IR: end_to_tap = TAP_PAUSE_IR;
      default:      end_to_tap = TAP_RESET;
    endcase
  endfunction

  // Next TMS on the shortest path, but a pause state asked for again loops through Update; pause states always leave first.
  function automatic logic tms_toward(input tps_tap_t s, input tps_tap_t t);
    logic v;
    v = 1'b1;
    case (t)
      TAP_RESET: v = 1'b1;
      TAP_IDLE:
        v = !(s == TAP_IDLE || s == TAP_RESET || s == TAP_UPD_DR || s == TAP_UPD_IR);
      TAP_SHIFT_DR:
        v = !(s == TAP_SHIFT_DR || s == TAP_EXIT2_DR || s == TAP_CAP_DR ||
              s == TAP_SEL_DR || s == TAP_EXIT1_DR || s == TAP_RESET);
      TAP_PAUSE_DR:
        v = !(s == TAP_SEL_DR || s == TAP_EXIT1_DR || s == TAP_RESET);
      TAP_SHIFT_IR:
        v = !(s == TAP_SHIFT_IR || s == TAP_EXIT2_IR || s == TAP_CAP_IR ||
              s == TAP_SEL_IR || s == TAP_EXIT1_IR || s == TAP_RESET);
      TAP_PAUSE_IR:
        v = !(s == TAP_SEL_IR || s == TAP_EXIT1_IR || s == TAP_RESET);
      default: v = 1'b1;
    endcase
    return v;
  endfunction

  // ----------------------------------------------------------------------
  // Sequence control
  // ----------------------------------------------------------------------
  logic     busy_q;
  logic     moved_q;
  logic     parked_q;
  logic     done_q;
  logic     drove_q;
  logic     host_q;
  tps_tap_t target_q;
  logic     arrived;
  logic     start_cmd;
  logic     start_park;
  logic     start_resume;
  logic     in_shift;

  assign arrived   = moved_q && (cur == target_q);
  assign in_shift  = (cur == TAP_SHIFT_DR) || (cur == TAP_SHIFT_IR);
  assign start_cmd = cmd_valid && !busy_q && !parked_q;

  // park only with a free clock
  assign start_park   = !busy_q && !cmd_valid && !parked_q && buf_stall &&
                        !gated_mode && in_shift;
  assign start_resume = !busy_q && parked_q && !buf_stall;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      busy_q   <= 1'b0;
      target_q <= TAP_STATE_RST;
    end else if (start_cmd) begin
      busy_q   <= 1'b1;
      target_q <= end_to_tap(cmd_end);
    end else if (start_park) begin
      busy_q   <= 1'b1;
      target_q <= (cur == TAP_SHIFT_DR) ? TAP_PAUSE_DR : TAP_PAUSE_IR;
    end else if (start_resume) begin
      busy_q   <= 1'b1;
      target_q <= (target_q == TAP_PAUSE_DR) ? TAP_SHIFT_DR : TAP_SHIFT_IR;
    end else if (busy_q && arrived && tck_fall) begin
      busy_q   <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      parked_q <= 1'b0;
    end else if (start_park) begin
      parked_q <= 1'b1;
    end else if (start_resume) begin
      parked_q <= 1'b0;
    end
  end

  // first value driven
  // A rising edge before the first driven value still carries the old looping level,
  // so it must not set moved_q, or a same-state scan would end at once.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      drove_q <= 1'b0;
    end else if (start_cmd || start_park || start_resume) begin
      drove_q <= 1'b0;
    end else if (busy_q && tck_fall) begin
      drove_q <= 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      host_q <= 1'b0;
    end else if (start_cmd) begin
      host_q <= 1'b1;
    end else if (start_park || start_resume) begin
      host_q <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      moved_q <= 1'b0;
    end else if (start_cmd || start_park || start_resume) begin
      moved_q <= 1'b0;
    end else if (busy_q && drove_q && tck_rise) begin
      moved_q <= 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      tms_q <= TMS_RST;
    end else if (tck_fall) begin
      if (busy_q && !arrived) begin
        tms_q <= tms_toward(cur, target_q);
      end else begin
        tms_q <= (cur == TAP_RESET);
      end
    end
  end

  // A command ends one falling edge after arrival, so TMS is already settled.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      done_q <= 1'b0;
    end else begin
      done_q <= busy_q && arrived && tck_fall && host_q;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  logic ready_q;
  logic [TAP_STATE_W-1:0] field_q;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ready_q <= 1'b0;
      field_q <= TAP_STATE_RST;
    end else begin
      ready_q <= !busy_q && !parked_q && !start_cmd && !start_park && !start_resume;
      field_q <= stp.state;
    end
  end

  assign cmd_ready       = ready_q;
  assign cmd_done        = done_q;
  assign buf_parked      = parked_q;
  assign tms             = tms_q;
  assign tap_state_field = field_q;

endmodule // tps_sequencer

// ---- rtl/tps_pkg.sv ----
// Purpose: Shared types and reset values of the TAP path sequencer.
// Assumes: Targets follow the standard sixteen-state TAP controller.
// Notes:   Enumerations carry no fixed codes; the state field is four bits wide.
package tps_pkg;

  // ----------------------------------------------------------------------
  // TAP controller states
  // ----------------------------------------------------------------------
  typedef enum logic [3:0] {
    TAP_RESET,
    TAP_IDLE,
    TAP_SEL_DR,
    TAP_CAP_DR,
    TAP_SHIFT_DR,
    TAP_EXIT1_DR,
    TAP_PAUSE_DR,
    TAP_EXIT2_DR,
    TAP_UPD_DR,
    TAP_SEL_IR,
    TAP_CAP_IR,
    TAP_SHIFT_IR,
    TAP_EXIT1_IR,
    TAP_PAUSE_IR,
    TAP_EXIT2_IR,
    TAP_UPD_IR
  } tps_tap_t;

  // ----------------------------------------------------------------------
  // Requested end states
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    END_RESET,
    END_IDLE,
    END_SHIFT_DR,
    END_PAUSE_DR,
    END_SHIFT_IR,
    END_PAUSE_IR
  } tps_end_t;

  localparam int       TAP_STATE_W    = 4;
  localparam tps_tap_t TAP_STATE_RST  = TAP_RESET;
  localparam logic     TMS_RST        = 1'b1;
  localparam tps_end_t END_RST        = END_RESET;

endpackage

// ---- rtl/tps_step_if.sv ----
// Purpose: Carries one TAP step from the sequencer to the state tracker.
// Assumes: Both ends run on the same system clock.
// Notes:   The step pulse marks a rising test-clock edge seen by the targets.
`timescale 1ns/100ps
interface tps_step_if;
  import tps_pkg::*;
  logic     step;
  logic     tms;
  tps_tap_t state;
  modport src (output step, output tms, input state);
  modport trk (input step, input tms, output state);
endinterface

// ---- rtl/tps_tap_track.sv ----
// Purpose: Copy of the target TAP controller state, advanced on each step.
// Assumes: A step is given exactly when the targets sample TMS.
// Notes:   The state is a register, so it may be driven straight to a pin.
`timescale 1ns/100ps
module tps_tap_track
  import tps_pkg::*;
(
  input  wire logic clock,
  input  wire logic rst_n,
  tps_step_if.trk   stp
);

  tps_tap_t state_q;
  tps_tap_t state_d;

  // ----------------------------------------------------------------------
  // Standard TAP next state
  // ----------------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    case (state_q)
      TAP_RESET:    state_d = stp.tms ? TAP_RESET    : TAP_IDLE;
      TAP_IDLE:     state_d = stp.tms ? TAP_SEL_DR   : TAP_IDLE;
      TAP_SEL_DR:   state_d = stp.tms ? TAP_SEL_IR   : TAP_CAP_DR;
      TAP_CAP_DR:   state_d = stp.tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
      TAP_SHIFT_DR: state_d = stp.tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
      TAP_EXIT1_DR: state_d = stp.tms ? TAP_UPD_DR   : TAP_PAUSE_DR;
      TAP_PAUSE_DR: state_d = stp.tms ? TAP_EXIT2_DR : TAP_PAUSE_DR;
      TAP_EXIT2_DR: state_d = stp.tms ? TAP_UPD_DR   : TAP_SHIFT_DR;
      TAP_UPD_DR:   state_d = stp.tms ? TAP_SEL_DR   : TAP_IDLE;
      TAP_SEL_IR:   state_d = stp.tms ? TAP_RESET    : TAP_CAP_IR;
      TAP_CAP_IR:   state_d = stp.tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
      TAP_SHIFT_IR: state_d = stp.tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
      TAP_EXIT1_IR: state_d = stp.tms ? TAP_UPD_IR   : TAP_PAUSE_IR;
      TAP_PAUSE_IR: state_d = stp.tms ? TAP_EXIT2_IR : TAP_PAUSE_IR;
      TAP_EXIT2_IR: state_d = stp.tms ? TAP_UPD_IR   : TAP_SHIFT_IR;
      TAP_UPD_IR:   state_d = stp.tms ? TAP_SEL_DR   : TAP_IDLE;
      default:      state_d = TAP_RESET;
    endcase
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state_q <= TAP_STATE_RST;
    end else if (stp.step) begin
      state_q <= state_d;
    end
  end

  assign stp.state = state_q;

endmodule // tps_tap_track

// ---- sim/tps_tap_model.sv ----
// Purpose: Target TAP controller that follows TMS on each rising test-clock edge.
// Assumes: Power-up state is Test-Logic-Reset.
// Notes:   Counts state changes, so the bench can measure the length of each path.
`timescale 1ns/100ps
module tps_tap_model
  import tps_pkg::*;
(
  input  wire logic tck,
  input  wire logic tms,
  output tps_tap_t  state,
  output int        moves
);
  tps_tap_t nxt;
  always_comb begin
    case (state)
      TAP_RESET:    nxt = tms ? TAP_RESET : TAP_IDLE;
      TAP_IDLE:     nxt = tms ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_DR:   nxt = tms ? TAP_SEL_IR : TAP_CAP_DR;
      TAP_CAP_DR:   nxt = tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
      TAP_SHIFT_DR: nxt = tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
      TAP_EXIT1_DR: nxt = tms ? TAP_UPD_DR : TAP_PAUSE_DR;
      TAP_PAUSE_DR: nxt = tms ? TAP_EXIT2_DR : TAP_PAUSE_DR;
      TAP_EXIT2_DR: nxt = tms ? TAP_UPD_DR : TAP_SHIFT_DR;
      TAP_UPD_DR:   nxt = tms ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_IR:   nxt = tms ? TAP_RESET : TAP_CAP_IR;
      TAP_CAP_IR:   nxt = tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
      TAP_SHIFT_IR: nxt = tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
      TAP_EXIT1_IR: nxt = tms ? TAP_UPD_IR : TAP_PAUSE_IR;
      TAP_PAUSE_IR: nxt = tms ? TAP_EXIT2_IR : TAP_PAUSE_IR;
      TAP_EXIT2_IR: nxt = tms ? TAP_UPD_IR : TAP_SHIFT_IR;
      default:      nxt = tms ? TAP_SEL_DR : TAP_IDLE;
    endcase
  end
  initial begin
    state = TAP_RESET;
    moves = 0;
  end
  always @(posedge tck) begin
    if (nxt != state) moves <= moves + 1;
    state <= nxt;
  end
endmodule // tps_tap_model

// ---- sim/tps_seq_chk.sv ----
// Purpose: Port-level checks of the TAP path sequencer.
// Assumes: The test clock is many system cycles long per phase.
// Notes:   Windows are loose, so a sync chain one flop longer still passes.
`timescale 1ns/100ps
module tps_seq_chk
  import tps_pkg::*;
(
  input wire logic                   clock,
  input wire logic                   rst_n,
  input wire logic                   tck,
  input wire logic                   cmd_valid,
  input wire tps_end_t               cmd_end,
  input wire logic                   gated_mode,
  input wire logic                   buf_stall,
  input wire logic                   cmd_ready,
  input wire logic                   cmd_done,
  input wire logic                   buf_parked,
  input wire logic                   tms,
  input wire logic [TAP_STATE_W-1:0] tap_state_field
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  AST_RST_VAL: assert property ($rose(rst_n) |-> tms && !cmd_done && tap_state_field == 4'h0)
    else $error("tms or state wrong after reset");
  AST_TMS_AFTER_FALL: assert property ($changed(tms) |-> !tck && !$past(tck) && !$past(tck, 2))
    else $error("tms moved outside the low test-clock phase");
  AST_FIELD_AFTER_RISE: assert property ($changed(tap_state_field) |-> tck && $past(tck))
    else $error("state field moved outside the high test-clock phase");
  AST_DONE_PULSE: assert property (cmd_done |-> !cmd_ready ##1 (!cmd_done && cmd_ready))
    else $error("done pulse or ready return wrong");
  AST_TAKE: assert property (cmd_valid && cmd_ready |=> !cmd_ready [*8])
    else $error("command not taken");
  AST_DONE_BOUND: assert property (cmd_valid && cmd_ready |=> ##[1:160] cmd_done)
    else $error("command did not finish in time");
  AST_RESET_HIGH: assert property (cmd_ready && tap_state_field == TAP_RESET |-> tms)
    else $error("tms low while idle in reset");
  AST_GATED_HOLD: assert property (gated_mode && !buf_parked |=> !buf_parked)
    else $error("parked in gated mode");
  AST_PARK_PAUSE: assert property ($rose(buf_parked) |-> ##[1:80]
    (tap_state_field == TAP_PAUSE_DR || tap_state_field == TAP_PAUSE_IR))
    else $error("parked outside a pause state");
  COV_DONE: cover property (cmd_done);
  COV_PARK: cover property ($rose(buf_parked));
  COV_GATED: cover property (gated_mode && buf_stall);
endmodule // tps_seq_chk
bind tps_sequencer tps_seq_chk u_chk (.clock(clock), .rst_n(rst_n), .tck(tck),
  .cmd_valid(cmd_valid), .cmd_end(cmd_end), .gated_mode(gated_mode), .buf_stall(buf_stall),
  .cmd_ready(cmd_ready), .cmd_done(cmd_done), .buf_parked(buf_parked), .tms(tms),
  .tap_state_field(tap_state_field));

// ---- sim/tps_sequencer_test.sv ----
// Purpose: Walks the sequencer through every end state, each command starting where the last one ended.
// Assumes: Test clock runs free at 160 ns, in fixed phase with the system clock, each edge 2 ns before a rising one.
// Notes:   Path length is the count of target state changes per command.
`timescale 1ns/100ps
module tps_sequencer_test;
  import tps_pkg::*;
  logic clock, rst_n, tck, cmd_valid, gated_mode, buf_stall;
  logic cmd_ready, cmd_done, buf_parked, tms;
  logic [TAP_STATE_W-1:0] tap_state_field;
  tps_end_t cmd_end;
  tps_tap_t tgt_state;
  int       moves, fail_count, compares;
  tps_sequencer uut (.clock(clock), .rst_n(rst_n), .tck(tck), .cmd_valid(cmd_valid),
    .cmd_end(cmd_end), .gated_mode(gated_mode), .buf_stall(buf_stall), .cmd_ready(cmd_ready),
    .cmd_done(cmd_done), .buf_parked(buf_parked), .tms(tms), .tap_state_field(tap_state_field));
  tps_tap_model u_tgt (.tck(tck), .tms(tms), .state(tgt_state), .moves(moves));
  initial begin
    clock = 0;
    forever #5 clock = ~clock;
  end
  initial begin
    tck = 0;
    #3;
    forever #80 tck = ~tck;
  end
  task automatic tick();
    @(posedge clock);
    #1;
  endtask
  task automatic check(input logic [3:0] seen, input logic [3:0] exp);
    compares++;
    if (seen !== exp) begin
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      fail_count++;
    end
  endtask
  function automatic tps_tap_t tap_of(input tps_end_t e);
    case (e)
      END_RESET:    return TAP_RESET;
      END_IDLE:     return TAP_IDLE;
      END_SHIFT_DR: return TAP_SHIFT_DR;
      END_PAUSE_DR: return TAP_PAUSE_DR;
      END_SHIFT_IR: return TAP_SHIFT_IR;
      default:      return TAP_PAUSE_IR;
    endcase
  endfunction
  // Takes one command and judges end state, looping TMS value and path length.
  task automatic run(input tps_end_t e, input int steps);
    int n;
    int base;
    for (n = 0; n < 50 && cmd_ready !== 1'b1; n++) tick();
    base = moves;
    cmd_end = e;
    cmd_valid = 1'b1;
    tick();
    cmd_valid = 1'b0;
    for (n = 0; n < 300 && cmd_done !== 1'b1; n++) tick();
    check(4'(cmd_done), 4'h1);
    tick();
    tick();
    check(tap_state_field, tap_of(e));
    check(tgt_state, tap_of(e));
    check(4'(moves - base), 4'(steps));
    check(4'(tms), 4'(tap_of(e) == TAP_RESET));
  endtask
  // Parks on a free clock, resumes, then stays in Shift on a gated clock.
  task automatic stall();
    int n;
    int pulses;
    pulses = 0;
    buf_stall = 1'b1;
    for (n = 0; n < 300 && tgt_state !== TAP_PAUSE_DR; n++) begin
      tick();
      pulses += cmd_done;
    end
    repeat (40) tick();
    check(tgt_state, TAP_PAUSE_DR);
    check(4'({buf_parked, tms}), 4'h2);
    buf_stall = 1'b0;
    for (n = 0; n < 300 && tgt_state !== TAP_SHIFT_DR; n++) tick();
    check(tgt_state, TAP_SHIFT_DR);
    gated_mode = 1'b1;
    buf_stall = 1'b1;
    for (n = 0; n < 100; n++) begin
      tick();
      pulses += cmd_done;
    end
    check(tgt_state, TAP_SHIFT_DR);
    check(4'({buf_parked, tms}), 4'h0);
    check(4'(pulses), 4'h0);
    buf_stall = 1'b0;
    gated_mode = 1'b0;
  endtask
  task automatic results();
    $display("compares=%0d fail_count=%0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    #200000;
    fail_count++;
    results();
  end
  initial begin
    {rst_n, cmd_valid, gated_mode, buf_stall} = 4'h0;
    cmd_end = END_RESET;
    fail_count = 0;
    compares = 0;
    repeat (4) tick();
    check(4'({tms, cmd_ready}), 4'h2);
    rst_n = 1'b1;
    run(END_SHIFT_DR, 4);
    run(END_PAUSE_DR, 2);
    run(END_SHIFT_DR, 2);
    run(END_PAUSE_IR, 7);
    run(END_RESET, 5);
    run(END_PAUSE_IR, 6);
    run(END_IDLE, 3);
    run(END_SHIFT_IR, 4);
    run(END_PAUSE_DR, 6);
    run(END_PAUSE_DR, 6);
    run(END_SHIFT_IR, 6);
    run(END_PAUSE_IR, 2);
    run(END_PAUSE_IR, 7);
    run(END_SHIFT_IR, 2);
    run(END_RESET, 5);
    run(END_PAUSE_DR, 5);
    run(END_PAUSE_IR, 7);
    run(END_SHIFT_DR, 5);
    run(END_IDLE, 3);
    run(END_PAUSE_DR, 4);
    run(END_IDLE, 3);
    run(END_SHIFT_IR, 4);
    run(END_IDLE, 3);
    run(END_PAUSE_IR, 5);
    run(END_PAUSE_DR, 6);
    run(END_RESET, 5);
    run(END_SHIFT_DR, 4);
    stall();
    run(END_RESET, 5);
    results();
  end
endmodule // tps_sequencer_test
